//--- eeprom_rd_pkg.sv
// Shared constants for the serial EEPROM read port and its master
`default_nettype none
package eeprom_rd_pkg;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned MEM_DEPTH  = 4096;
    localparam logic [3:0]  DEV_CODE   = 4'b1010;
    localparam logic [11:0] ADDR_LAST  = 12'hFFF;
    localparam logic [11:0] ADDR_ZERO  = 12'h000;
    localparam logic [3:0]  BIT_LAST   = 4'h7;
    localparam logic [3:0]  BIT_ZERO   = 4'h0;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam int unsigned CLK_HZ     = 20_000_000;
    localparam int unsigned LINK_HZ    = 400_000;
    // Master half period of the link clock in system cycles
    localparam int unsigned HALF_CYC   = CLK_HZ / (2 * LINK_HZ);
    localparam logic [7:0]  HALF_CNT   = 8'(HALF_CYC - 1);
    localparam logic [7:0]  CNT_ZERO   = 8'h00;
    // Master command codes
    localparam logic [1:0]  CMD_CUR    = 2'h0;
    localparam logic [1:0]  CMD_RAND   = 2'h1;
    localparam logic [1:0]  CMD_WRITE  = 2'h2;
    localparam logic [1:0]  CMD_WDATA  = 2'h3;
endpackage

`default_nettype wire

//--- eeprom_link_if.sv
// Two-wire link between the EEPROM end and the bus master end
`timescale 1ns/1ps
`default_nettype none
interface eeprom_link_if;
    logic scl;
    logic sda;
    logic sda_dev_oe;
    logic sda_mst_oe;
    logic scl_mst_o;
    // Open drain: pulled up unless someone pulls low
    assign sda = ~(sda_dev_oe | sda_mst_oe);
    assign scl = scl_mst_o;
    modport device (input scl, input sda, output sda_dev_oe);
    modport master (input sda, output scl_mst_o, output sda_mst_oe);
endinterface
`default_nettype wire

//--- eeprom_rd_dev.sv
// EEPROM end: serial slave serving reads from a 4096-byte array
// Notes on behaviour
// - Read uses write framing with read bit one
// - Counter holds last address plus one
// - Matching read control byte acked, byte out
// - Master nacks then STOP; device stops sending
// - Dummy write sets address; restart aborts write
// - After random read counter points past byte
// - Master ack requests next sequential byte
// - Pointer increments, wraps from top to zero
// - Three chip select pins must match
// - Data line only pulled low or released
// - Data changes only while clock low
// - Write protect high blocks array writes
// - Write protect low allows full access
// - Control byte needs fixed device code
// - Address two bytes, high first, 12 bits
// - No ack during internal write cycle
// - On master nack release data line
`timescale 1ns/1ps
`default_nettype none
module eeprom_rd_dev
    import eeprom_rd_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    eeprom_link_if.device link,
    input  wire logic chip_sel_in_low,
    input  wire logic chip_sel_in_mid,
    input  wire logic chip_sel_in_high,
    input  wire logic write_protect,
    input  wire logic write_busy,
    output logic      array_wr_en,
    output logic [11:0] array_wr_addr,
    output logic [7:0]  array_wr_data,
    input  wire logic   wr_ready
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_CTRL, ST_CTRL_ACK, ST_AHI, ST_AHI_ACK, ST_ALO,
        ST_ALO_ACK, ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
    } dev_state_e;

    typedef struct packed {
        logic [1:0]  scl_sync;
        logic [1:0]  sda_sync;
        logic        scl_prev;
        logic        sda_prev;
        dev_state_e  state;
        logic [3:0]  bit_cnt;
        logic [7:0]  shift;
        logic [11:0] addr;
        logic        drive_low;
        logic        is_write;
        logic        wr_valid;
        logic [11:0] wr_addr;
        logic [7:0]  wr_data;
    } dev_s;

    dev_s r_reg;
    dev_s r_next;
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] rd_byte;

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [2:0] pins;

    assign scl_s      = r_reg.scl_sync[1];
    assign sda_s      = r_reg.sda_sync[1];
    assign scl_rise   = scl_s & ~r_reg.scl_prev;
    assign scl_fall   = ~scl_s & r_reg.scl_prev;
    // Data edge while clock high frames a transfer
    assign start_seen = scl_s & r_reg.scl_prev & r_reg.sda_prev & ~sda_s;
    assign stop_seen  = scl_s & r_reg.scl_prev & ~r_reg.sda_prev & sda_s;
    assign pins = {chip_sel_in_high, chip_sel_in_mid, chip_sel_in_low};
    assign rd_byte = mem[r_reg.addr];

    // Open-drain: only ever pulls low
    assign link.sda_dev_oe = r_reg.drive_low;
    assign array_wr_en     = r_reg.wr_valid;
    assign array_wr_addr   = r_reg.wr_addr;
    assign array_wr_data   = r_reg.wr_data;

    always_comb begin
        r_next = r_reg;
        r_next.scl_sync = {r_reg.scl_sync[0], link.scl};
        r_next.sda_sync = {r_reg.sda_sync[0], link.sda};
        r_next.scl_prev = scl_s;
        r_next.sda_prev = sda_s;
        // One-entry handoff: hold the word until the array accepts it
        if (r_reg.wr_valid && wr_ready) begin
            r_next.wr_valid = 1'b0;
        end
        if (start_seen) begin
            // Repeated start aborts a write but keeps the address
            r_next.state     = ST_CTRL;
            r_next.bit_cnt   = BIT_ZERO;
            r_next.drive_low = 1'b0;
        end else if (stop_seen) begin
            r_next.state     = ST_IDLE;
            r_next.drive_low = 1'b0;
        end else begin
            unique case (r_reg.state)
                ST_IDLE: begin
                    r_next.drive_low = 1'b0;
                end
                ST_CTRL, ST_AHI, ST_ALO, ST_WDATA: begin
                    if (scl_rise) begin
                        r_next.shift   = {r_reg.shift[6:0], sda_s};
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    end
                    if (scl_fall && r_reg.bit_cnt == BIT_LAST + 4'h1) begin
                        r_next.bit_cnt = BIT_ZERO;
                        if (r_reg.state == ST_CTRL) begin
                            if (r_reg.shift[7:4] == DEV_CODE &&
                                r_reg.shift[3:1] == pins &&
                                !write_busy) begin
                                r_next.drive_low = 1'b1;
                                r_next.is_write  = ~r_reg.shift[0];
                                r_next.state     = ST_CTRL_ACK;
                            end else begin
                                r_next.state = ST_IDLE;
                            end
                        end else if (r_reg.state == ST_AHI) begin
                            // Top four address bits are ignored
                            r_next.addr[11:8] = r_reg.shift[3:0];
                            r_next.drive_low  = 1'b1;
                            r_next.state      = ST_AHI_ACK;
                        end else if (r_reg.state == ST_ALO) begin
                            r_next.addr[7:0] = r_reg.shift;
                            r_next.drive_low = 1'b1;
                            r_next.state     = ST_ALO_ACK;
                        end else begin
                            r_next.drive_low = 1'b1;
                            r_next.state     = ST_WDATA_ACK;
                            if (!write_protect && !r_reg.wr_valid) begin
                                r_next.wr_valid = 1'b1;
                                r_next.wr_addr  = r_reg.addr;
                                r_next.wr_data  = r_reg.shift;
                            end
                            r_next.addr = r_reg.addr + 12'h001;
                        end
                    end
                end
                ST_CTRL_ACK: begin
                    if (scl_fall) begin
                        if (r_reg.is_write) begin
                            r_next.drive_low = 1'b0;
                            r_next.state     = ST_AHI;
                        end else begin
                            // First data bit from counter address
                            r_next.shift     = rd_byte;
                            r_next.drive_low = ~rd_byte[7];
                            r_next.bit_cnt   = BIT_ZERO;
                            r_next.state     = ST_RDATA;
                        end
                    end
                end
                ST_AHI_ACK, ST_ALO_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        r_next.drive_low = 1'b0;
                        r_next.state = (r_reg.state == ST_AHI_ACK) ? ST_ALO
                                                                    : ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (r_reg.bit_cnt == BIT_LAST) begin
                            // Release for master ack slot
                            r_next.drive_low = 1'b0;
                            r_next.state     = ST_RACK;
                            r_next.addr = (r_reg.addr == ADDR_LAST) ? ADDR_ZERO
                                : r_reg.addr + 12'h001;
                        end else begin
                            r_next.bit_cnt   = r_reg.bit_cnt + 4'h1;
                            r_next.shift     = {r_reg.shift[6:0], 1'b0};
                            r_next.drive_low = ~r_reg.shift[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            r_next.state = ST_IDLE;
                        end else begin
                            r_next.bit_cnt = BIT_LAST + 4'h1;
                        end
                    end
                    if (scl_fall && r_reg.bit_cnt == BIT_LAST + 4'h1) begin
                        r_next.shift     = rd_byte;
                        r_next.drive_low = ~rd_byte[7];
                        r_next.bit_cnt   = BIT_ZERO;
                        r_next.state     = ST_RDATA;
                    end
                end
                default: r_next.state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '{scl_sync: 2'b11, sda_sync: 2'b11, scl_prev: 1'b1,
                       sda_prev: 1'b1, state: ST_IDLE, bit_cnt: 4'h0,
                       shift: 8'h00, addr: 12'h000, drive_low: 1'b0,
                       is_write: 1'b0, wr_valid: 1'b0, wr_addr: 12'h000,
                       wr_data: 8'h00};
        end else begin
            r_reg <= r_next;
        end
    end

    // Power-up content: every byte holds its own low address bits
    initial begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] = 8'(i);
        end
    end

    // Array storage, written by the handed-off write word
    always @(posedge clk) begin
        if (r_reg.wr_valid && wr_ready) begin
            mem[r_reg.wr_addr] <= r_reg.wr_data;
        end
    end
endmodule // eeprom_rd_dev
`default_nettype wire

//--- eeprom_rd_mst.sv
// Bus master end: issues current, random and write-address transfers
`timescale 1ns/1ps
`default_nettype none
module eeprom_rd_mst
    import eeprom_rd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    eeprom_link_if.master    link,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [1:0]  cmd_op,
    input  wire logic [2:0]  cmd_chip,
    input  wire logic [11:0] cmd_addr,
    input  wire logic [7:0]  cmd_count,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [7:0]       rd_data,
    output logic             nack_err
);
    typedef enum logic [3:0] {
        M_IDLE, M_START, M_BYTE, M_ACK, M_RESTART, M_RBYTE, M_RACK,
        M_STOP, M_DONE
    } mst_state_e;

    typedef struct packed {
        logic [1:0]  sda_sync;
        mst_state_e  state;
        logic [7:0]  cnt;
        logic        phase;
        logic [1:0]  step;
        logic [3:0]  bit_cnt;
        logic [7:0]  shift;
        logic [1:0]  byte_idx;
        logic [1:0]  op;
        logic [2:0]  chip;
        logic [11:0] addr;
        logic [7:0]  left;
        logic        scl_o;
        logic        sda_low;
        logic        err;
        logic [1:0]  fifo_cnt;
        logic        fifo_wp;
        logic        fifo_rp;
        logic [15:0] fifo_mem;
    } mst_s;

    mst_s r_reg;
    mst_s r_next;
    logic tick;
    logic sda_s;
    logic fifo_full;

    assign tick      = (r_reg.cnt == HALF_CNT);
    assign sda_s     = r_reg.sda_sync[1];
    assign fifo_full = r_reg.fifo_cnt[1];
    assign cmd_ready = (r_reg.state == M_IDLE);
    assign rd_valid  = (r_reg.fifo_cnt != 2'd0);
    assign rd_data   = r_reg.fifo_rp ? r_reg.fifo_mem[15:8]
                                     : r_reg.fifo_mem[7:0];
    assign nack_err  = r_reg.err;
    assign link.scl_mst_o  = r_reg.scl_o;
    assign link.sda_mst_oe = r_reg.sda_low;

    always_comb begin
        r_next = r_reg;
        r_next.sda_sync = {r_reg.sda_sync[0], link.sda};
        r_next.cnt = tick ? CNT_ZERO : r_reg.cnt + 8'h01;
        if (rd_valid && rd_ready) begin
            r_next.fifo_rp = ~r_reg.fifo_rp;
            r_next.fifo_cnt = r_reg.fifo_cnt - 2'd1;
        end
        unique case (r_reg.state)
            M_IDLE: begin
                if (cmd_valid) begin
                    r_next.op = cmd_op;
                    r_next.chip = cmd_chip;
                    r_next.addr = cmd_addr;
                    r_next.left = cmd_count;
                    r_next.err = 1'b0;
                    r_next.byte_idx = 2'd0;
                    r_next.step = 2'd0;
                    r_next.state = M_START;
                end
            end
            M_START, M_RESTART: if (tick) begin
                r_next.step = r_reg.step + 2'd1;
                unique case (r_reg.step)
                    2'd0: r_next.sda_low = 1'b0;
                    2'd1: r_next.scl_o = 1'b1;
                    2'd2: r_next.sda_low = 1'b1;
                    2'd3: begin
                        r_next.scl_o = 1'b0;
                        r_next.bit_cnt = BIT_ZERO;
                        // Random read sends a write control byte first
                        r_next.shift = {DEV_CODE, r_reg.chip,
                            (r_reg.state == M_START && r_reg.op != CMD_CUR)
                                ? 1'b0 : 1'b1};
                        r_next.state = M_BYTE;
                    end
                endcase
            end
            M_BYTE: if (tick) begin
                if (!r_reg.scl_o) begin
                    r_next.sda_low = ~r_reg.shift[7];
                    r_next.scl_o = 1'b1;
                end else begin
                    r_next.scl_o = 1'b0;
                    r_next.shift = {r_reg.shift[6:0], 1'b0};
                    r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    if (r_reg.bit_cnt == BIT_LAST) begin
                        r_next.state = M_ACK;
                    end
                end
            end
            M_ACK: if (tick) begin
                if (!r_reg.scl_o) begin
                    r_next.sda_low = 1'b0;
                    r_next.scl_o = 1'b1;
                end else begin
                    r_next.scl_o = 1'b0;
                    r_next.bit_cnt = BIT_ZERO;
                    r_next.byte_idx = r_reg.byte_idx + 2'd1;
                    r_next.step = 2'd0;
                    if (sda_s) begin
                        r_next.err = 1'b1;
                        r_next.state = M_STOP;
                    end else if (r_reg.shift[0] == 1'b0 &&
                                 r_reg.byte_idx == 2'd0 && r_reg.op != CMD_CUR
                                 && r_reg.state == M_ACK &&
                                 r_reg.left != BYTE_ZERO &&
                                 r_reg.byte_idx != 2'd3) begin
                        r_next.shift = {4'h0, r_reg.addr[11:8]};
                        r_next.state = M_BYTE;
                    end else if (r_reg.byte_idx == 2'd1) begin
                        r_next.shift = r_reg.addr[7:0];
                        r_next.state = M_BYTE;
                    end else if (r_reg.byte_idx == 2'd2 &&
                                 r_reg.op == CMD_WDATA) begin
                        // Data word for a write test: inverted low address
                        r_next.shift = ~r_reg.addr[7:0];
                        r_next.state = M_BYTE;
                    end else if (r_reg.byte_idx == 2'd2 ||
                                 r_reg.op == CMD_WDATA) begin
                        r_next.state = (r_reg.op == CMD_RAND) ? M_RESTART
                                                              : M_STOP;
                    end else begin
                        r_next.state = M_RBYTE;
                    end
                end
            end
            M_RBYTE: if (tick && !fifo_full) begin
                if (!r_reg.scl_o) begin
                    r_next.sda_low = 1'b0;
                    r_next.scl_o = 1'b1;
                end else begin
                    r_next.scl_o = 1'b0;
                    r_next.shift = {r_reg.shift[6:0], sda_s};
                    r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    if (r_reg.bit_cnt == BIT_LAST) begin
                        r_next.state = M_RACK;
                        r_next.left = r_reg.left - 8'h01;
                        r_next.fifo_cnt = r_next.fifo_cnt + 2'd1;
                        r_next.fifo_wp = ~r_reg.fifo_wp;
                        if (r_reg.fifo_wp) begin
                            r_next.fifo_mem[15:8] = {r_reg.shift[6:0], sda_s};
                        end else begin
                            r_next.fifo_mem[7:0] = {r_reg.shift[6:0], sda_s};
                        end
                    end
                end
            end
            M_RACK: if (tick) begin
                if (!r_reg.scl_o) begin
                    // Ack for more bytes, nack on the last
                    r_next.sda_low = (r_reg.left != BYTE_ZERO);
                    r_next.scl_o = 1'b1;
                end else begin
                    r_next.scl_o = 1'b0;
                    r_next.bit_cnt = BIT_ZERO;
                    r_next.step = 2'd0;
                    r_next.state = (r_reg.left != BYTE_ZERO) ? M_RBYTE
                                                             : M_STOP;
                end
            end
            M_STOP: if (tick) begin
                r_next.step = r_reg.step + 2'd1;
                unique case (r_reg.step)
                    2'd0: r_next.sda_low = 1'b1;
                    2'd1: r_next.scl_o = 1'b1;
                    2'd2: r_next.sda_low = 1'b0;
                    2'd3: r_next.state = M_DONE;
                endcase
            end
            M_DONE: r_next.state = M_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '{sda_sync: 2'b11, state: M_IDLE, cnt: 8'h00,
                       phase: 1'b0, step: 2'd0, bit_cnt: 4'h0,
                       shift: 8'h00, byte_idx: 2'd0, op: 2'd0, chip: 3'd0,
                       addr: 12'h000, left: 8'h00, scl_o: 1'b1,
                       sda_low: 1'b0, err: 1'b0, fifo_cnt: 2'd0,
                       fifo_wp: 1'b0, fifo_rp: 1'b0, fifo_mem: 16'h0000};
        end else begin
            r_reg <= r_next;
        end
    end
endmodule // eeprom_rd_mst
`default_nettype wire

//--- eeprom_link_checker.sv
// Wire-level assertions on the two-wire link between both ends
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe,
    input wire logic sda_mst_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [3:0] slot_reg;
    logic       quiet_reg;
    logic       frame_reg;
    logic       scl_q_reg;
    logic       sda_q_reg;
    wire        start_w = scl && scl_q_reg && sda_q_reg && !sda;
    wire        stop_w  = scl && scl_q_reg && !sda_q_reg && sda;

    // Bit slot within a byte, nack seen, inside a frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_reg  <= 4'hF;
            quiet_reg <= 1'b0;
            frame_reg <= 1'b0;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl;
            sda_q_reg <= sda;
            if (start_w) begin
                slot_reg  <= 4'hF;
                quiet_reg <= 1'b0;
                frame_reg <= 1'b1;
            end else if (stop_w) begin
                frame_reg <= 1'b0;
            end else if (scl_q_reg && !scl) begin
                slot_reg <= (slot_reg == 4'h8) ? 4'h0 : slot_reg + 4'h1;
                if (slot_reg == 4'h8 && sda_q_reg) begin
                    quiet_reg <= 1'b1;
                end
            end
        end
    end

    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence

    property p_dev_change_low;
        $changed(sda_dev_oe) |-> !scl && !$past(scl);
    endproperty
    a_dev_change_low: assert property (p_dev_change_low)
        else $error("device data changed while clock high");
    property p_dev_hold_high;
        $rose(scl) |-> $stable(sda_dev_oe) [*8];
    endproperty
    a_dev_hold_high: assert property (p_dev_hold_high)
        else $error("device data not held after clock rise");
    property p_no_clash;
        scl |-> !(sda_dev_oe && sda_mst_oe);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends pull data while clock high");
    property p_start_frame;
        s_start |-> scl [*8] ##[1:300] !scl;
    endproperty
    a_start_frame: assert property (p_start_frame)
        else $error("start not followed by a proper clock low");
    property p_stop_idle;
        s_stop |-> (scl && !sda_dev_oe) [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("device drives data after stop");
    property p_quiet_after_nack;
        quiet_reg |-> !sda_dev_oe;
    endproperty
    a_quiet_after_nack: assert property (p_quiet_after_nack)
        else $error("device drives data after a nack");
    property p_dev_idle;
        !frame_reg |-> !sda_dev_oe;
    endproperty
    a_dev_idle: assert property (p_dev_idle)
        else $error("device drives data outside a frame");
    property p_low_phase;
        $fell(scl) |-> (!scl) [*8];
    endproperty
    a_low_phase: assert property (p_low_phase)
        else $error("clock low phase too short");
endmodule // eeprom_link_checker
`default_nettype wire

//--- serial_eeprom_read_port_test.sv
// Self-checking bench joining the master end and the EEPROM end
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_port_test;
    import eeprom_rd_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        rd_ready = 1'b1;
    logic        write_protect = 1'b0;
    logic        write_busy = 1'b0;
    logic [1:0]  cmd_op = CMD_CUR;
    logic [2:0]  cmd_chip = 3'h5;
    logic [11:0] cmd_addr = ADDR_ZERO;
    logic [7:0]  cmd_count = 8'h01;
    logic        cmd_ready, rd_valid, nack_err, array_wr_en;
    logic [7:0]  rd_data, array_wr_data, da, db, dw;
    logic [11:0] array_wr_addr;
    logic [7:0]  got [$];
    int          mismatches = 0;
    int          checks_done = 0;
    int          wr_seen = 0;

    eeprom_link_if eeprom_link_if_inst ();
    eeprom_rd_dev eeprom_rd_dev_inst (.clk(clk), .rst_n(rst_n),
        .link(eeprom_link_if_inst.device), .chip_sel_in_low(1'b1),
        .chip_sel_in_mid(1'b0), .chip_sel_in_high(1'b1),
        .write_protect(write_protect), .write_busy(write_busy),
        .array_wr_en(array_wr_en), .array_wr_addr(array_wr_addr),
        .array_wr_data(array_wr_data), .wr_ready(1'b1));
    eeprom_rd_mst eeprom_rd_mst_inst (.clk(clk), .rst_n(rst_n),
        .link(eeprom_link_if_inst.master), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_chip(cmd_chip),
        .cmd_addr(cmd_addr), .cmd_count(cmd_count), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .nack_err(nack_err));
    eeprom_link_checker eeprom_link_checker_inst (.clk(clk), .rst_n(rst_n),
        .scl(eeprom_link_if_inst.scl), .sda(eeprom_link_if_inst.sda),
        .sda_dev_oe(eeprom_link_if_inst.sda_dev_oe),
        .sda_mst_oe(eeprom_link_if_inst.sda_mst_oe));

    always #25 clk = ~clk;
    always @(posedge clk) if (array_wr_en === 1'b1) wr_seen++;

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One command; bytes collected while the reader may stall first
    task automatic xfer(input logic [1:0] op, input logic [11:0] addr,
                        input logic [7:0] count, input int stall);
        int n;
        got.delete();
        @(negedge clk);
        cmd_op = op;
        cmd_addr = addr;
        cmd_count = count;
        cmd_valid = 1'b1;
        rd_ready = (stall == 0);
        @(negedge clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 40000; n++) begin
            @(negedge clk);
            if (n == stall) rd_ready = 1'b1;
            if (rd_valid && rd_ready) got.push_back(rd_data);
            if (cmd_ready && !rd_valid && n > stall) break;
        end
        if (n == 40000) check("command done", 8'h01, 8'h00);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        xfer(CMD_RAND, 12'h123, 8'h01, 0);
        da = got[0];
        check("random bytes", 8'h01, 8'(got.size()));
        check("random data", 8'h23, da);
        xfer(CMD_CUR, ADDR_ZERO, 8'h01, 0);
        db = got[0];
        check("current data", 8'h24, db);
        xfer(CMD_RAND, 12'h124, 8'h01, 0);
        check("next byte", db, got[0]);
        xfer(CMD_RAND, 12'h122, 8'h03, 0);
        check("seq second", da, got[1]);
        check("seq third", db, got[2]);
        $display("test sequential done");
        // Reader stalls until the buffer is full and the clock held low
        xfer(CMD_RAND, ADDR_LAST, 8'h03, 6000);
        dw = got[1];
        check("wrap bytes", 8'h03, 8'(got.size()));
        check("wrap top", 8'hFF, got[0]);
        check("wrap zero", 8'h00, dw);
        check("stalled third", 8'h01, got[2]);
        xfer(CMD_RAND, ADDR_ZERO, 8'h01, 0);
        check("wrap data", dw, got[0]);
        $display("test wrap done");
        write_protect = 1'b1;
        xfer(CMD_WRITE, 12'h123, 8'h01, 0);
        xfer(CMD_CUR, ADDR_ZERO, 8'h01, 0);
        check("protected read", da, got[0]);
        check("protected nack", 8'h00, 8'(nack_err));
        xfer(CMD_WDATA, 12'h123, 8'h01, 0);
        xfer(CMD_RAND, 12'h123, 8'h01, 0);
        check("protected data", 8'h23, got[0]);
        check("protected writes", 8'h00, 8'(wr_seen));
        write_protect = 1'b0;
        xfer(CMD_WDATA, 12'h300, 8'h01, 0);
        xfer(CMD_RAND, 12'h300, 8'h01, 0);
        check("written data", 8'hFF, got[0]);
        $display("test protect done");
        for (int c = 0; c < 8; c++) begin
            cmd_chip = 3'(c);
            xfer(CMD_CUR, ADDR_ZERO, 8'h01, 0);
            check("chip nack", 8'(c != 5), 8'(nack_err));
        end
        cmd_chip = 3'h5;
        $display("test chip select done");
        write_busy = 1'b1;
        xfer(CMD_RAND, 12'h123, 8'h01, 0);
        check("busy nack", 8'h01, 8'(nack_err));
        write_busy = 1'b0;
        check("array writes", 8'h01, 8'(wr_seen));
        $display("test busy done");
        wrap_up();
    end

    // Watchdog well past the expected run length
    initial begin
        #4_000_000;
        mismatches++;
        $display("unexpected watchdog: expected end seen hang");
        wrap_up();
    end
endmodule // serial_eeprom_read_port_test
`default_nettype wire
